// File: rtl/smc_pkg.sv
// Purpose: constants and types shared by the standby mode controller
// Assumes: 100 MHz hclk, AHB-Lite register slave with 32-bit data
// Notes: settle counts are in prescaled states
package smc_pkg;
	// register byte addresses
	localparam logic [7:0] SYS_CTRL_OFF = 8'hF0;
	localparam logic [7:0] MOD_HALT_OFF = 8'hF4;
	localparam logic [7:0] PRESCALE_OFF = 8'hF8;
	localparam logic [7:0] STATUS_OFF = 8'hFC;
	// reset values
	localparam logic [7:0] SYS_CTRL_RST = 8'h0B;
	localparam logic [7:0] MOD_HALT_RST = 8'h40;
	localparam logic [1:0] PRESCALE_RST = 2'h0;
	// system control and module halt field positions
	localparam int SSEL_BIT = 7;
	localparam int STS_LSB = 4;
	localparam int NMI_EDGE_SELECT_BIT = 3;
	localparam int ONCHIP_RAM_ENABLE_BIT = 0;
	localparam int MH_FIXED_BIT = 6;
	// settle wait in states per code, 000..101
	localparam logic [16:0] WAIT_C0 = 17'h02000;
	localparam logic [16:0] WAIT_C1 = 17'h04000;
	localparam logic [16:0] WAIT_C2 = 17'h08000;
	localparam logic [16:0] WAIT_C3 = 17'h10000;
	localparam logic [17:0] WAIT_C4 = 18'h20000;
	localparam logic [17:0] WAIT_C5 = 18'h00400;
	localparam int WAIT_W = 18;
	typedef enum logic [1:0] {SMC_RUN, SMC_SW_STANDBY_PIN_N, SMC_SETTLE, SMC_HW_STANDBY_PIN_N} smc_mode_t;
endpackage : smc_pkg

// File: rtl/smc_prescaler.sv
// Purpose: state-enable pulse divided from hclk by 1, 2, 4 or 8
// Assumes: one clock domain
// Notes: runs only while enabled so each wait starts aligned
`timescale 1ns/10ps
`default_nettype none
module smc_prescaler (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic run,
	input wire logic [1:0] sel,
	output logic tick
);
	logic [2:0] cnt_q;
	logic [2:0] mask;
	// mask of low bits that must be all ones to fire
	always_comb begin
		mask = 3'h0;
		unique case (sel)
			2'h0: mask = 3'h0;
			2'h1: mask = 3'h1;
			2'h2: mask = 3'h3;
			2'h3: mask = 3'h7;
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 3'h0;
		end else if (!run) begin
			cnt_q <= 3'h0;
		end else begin
			cnt_q <= cnt_q + 3'h1;
		end
	end
	assign tick = run && ((cnt_q & mask) == mask);
endmodule // smc_prescaler
`default_nettype wire

// File: rtl/smc_top.sv
// Purpose: software and hardware standby controller with AHB-Lite registers
// Assumes: pins synchronous to hclk; sleep_exec is a one-cycle pulse from the cpu
// Notes: hclk stands for the oscillator; clock gating shown as enables
// Behaviour
// RL1 - sleep with standby select set enters software standby, not sleep
// RL2 - software standby stops cpu, clock, modules; resets dma and modules
// RL3 - entry clears refresh counter and refresh status bits 7 and 6
// RL4 - software orders watchdog enable and standby select writes safely
// RL5 - software clears bus release enable before software standby
// RL6 - enabled nmi or irq0-2 restarts oscillator, waits settle, then interrupts
// RL7 - disabled or masked irq leaves device in software standby
// RL8 - reset low in software standby gives clocks at once, reset on rise
// RL9 - reset held low long enough for oscillator to stabilize
// RL10 - standby pin low in software standby enters hardware standby
// RL11 - settle select codes give 8192..131072 or 1024 states; 11x illegal
// RL12 - settle wait counts prescaled states; each prescale step doubles it
// RL13 - software picks settle settings giving at least 7 ms with crystal
// RL14 - nmi edge select picks falling (0) or rising (1) wake edge
// RL15 - standby pin low always enters hardware standby, resets, ports hi-z
// RL16 - software clears ram enable before standby pin goes low
// RL17 - mode pins stay unchanged during hardware standby
// RL18 - standby pin rise with reset low starts oscillator; reset rise runs
// RL19 - outside enters via reset then standby; exits standby, settle, reset
// RL20 - interrupt exit leaves standby select set; only software clears it (here standby pin low and hresetn also clear it)
// RL21 - module halt register survives software standby, reset by reset
`timescale 1ns/10ps
`default_nettype none
module smc_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic sleep_exec,
	input wire logic nmi_pin,
	input wire logic [2:0] irq_pin_n,
	input wire logic [2:0] irq_enable,
	input wire logic [2:0] irq_cpu_mask,
	input wire logic reset_pin_n,
	input wire logic standby_pin_n,
	output logic cpu_halt,
	output logic clock_run,
	output logic module_reset,
	output logic dma_reset,
	output logic refresh_init,
	output logic ports_hiz,
	output logic intr_start,
	output logic reset_start
);
	typedef struct packed {
		smc_pkg::smc_mode_t mode;
		logic [7:0] sysctl;
		logic [7:0] modhalt;
		logic [1:0] presc;
		logic [17:0] wait_cnt;
		logic ap_wr;
		logic [7:0] ap_addr;
		logic [31:0] rdata;
		logic nmi_prev;
		logic res_seen;
		logic cpu_halt;
		logic clock_run;
		logic module_reset;
		logic dma_reset;
		logic refresh_init;
		logic ports_hiz;
		logic intr_start;
		logic reset_start;
	} smc_state_t;

	smc_state_t s_q, s_d;
	logic tick;
	logic [17:0] wait_len;
	logic nmi_edge, irq_wake, wake;

	// prescaled state enable, only during the settle wait
	smc_prescaler u_presc (
		.hclk(hclk),
		.hresetn(hresetn),
		.run(s_q.mode == smc_pkg::SMC_SETTLE),
		.sel(s_q.presc),
		.tick(tick)
	);

	// wait length from the settle code; illegal codes take the longest
	always_comb begin
		unique case (s_q.sysctl[smc_pkg::STS_LSB +: 3]) // RL11
			3'h0: wait_len = {1'b0, smc_pkg::WAIT_C0};
			3'h1: wait_len = {1'b0, smc_pkg::WAIT_C1};
			3'h2: wait_len = {1'b0, smc_pkg::WAIT_C2};
			3'h3: wait_len = {1'b0, smc_pkg::WAIT_C3};
			3'h4: wait_len = smc_pkg::WAIT_C4;
			3'h5: wait_len = smc_pkg::WAIT_C5;
			default: wait_len = smc_pkg::WAIT_C4;
		endcase
	end

	// wake sources seen in software standby
	assign nmi_edge = s_q.sysctl[smc_pkg::NMI_EDGE_SELECT_BIT] ? (nmi_pin && !s_q.nmi_prev)
		: (!nmi_pin && s_q.nmi_prev); // RL14
	assign irq_wake = |(~irq_pin_n & irq_enable & ~irq_cpu_mask); // RL7
	assign wake = nmi_edge || irq_wake; // RL6

	always_comb begin
		s_d = s_q;
		s_d.intr_start = 1'b0;
		s_d.reset_start = 1'b0;
		s_d.refresh_init = 1'b0;
		s_d.nmi_prev = nmi_pin;
		// read data registered at the address phase, so it stands through the data phase
		// a read right behind a write to the same register still sees the old value
		s_d.rdata = 32'h00000000;
		if (hsel && hready && htrans[1] && !hwrite) begin
			unique case (haddr[7:0])
				smc_pkg::SYS_CTRL_OFF: s_d.rdata = {24'h000000, s_q.sysctl};
				smc_pkg::MOD_HALT_OFF: s_d.rdata = {24'h000000, s_q.modhalt};
				smc_pkg::PRESCALE_OFF: s_d.rdata = {30'h0, s_q.presc};
				smc_pkg::STATUS_OFF: s_d.rdata = {30'h0, s_q.mode};
				default: s_d.rdata = 32'h00000000;
			endcase
		end
		// write lands at the end of its data phase, when hwdata stands
		if (s_q.ap_wr) begin
			unique case (s_q.ap_addr)
				smc_pkg::SYS_CTRL_OFF: s_d.sysctl = hwdata[7:0]; // RL20
				smc_pkg::MOD_HALT_OFF: begin
					s_d.modhalt = hwdata[7:0];
					s_d.modhalt[smc_pkg::MH_FIXED_BIT] = 1'b1;
				end
				smc_pkg::PRESCALE_OFF: s_d.presc = hwdata[1:0];
				default: ;
			endcase
		end
		// address phase capture, any access size, only the low address byte kept
		s_d.ap_wr = hsel && hready && htrans[1] && hwrite;
		s_d.ap_addr = haddr[7:0];
		// power mode sequencing
		unique case (s_q.mode)
			smc_pkg::SMC_RUN: begin
				if (!reset_pin_n) begin
					s_d.res_seen = 1'b1;
				end
				if (sleep_exec && s_q.sysctl[smc_pkg::SSEL_BIT]) begin // RL1
					s_d.mode = smc_pkg::SMC_SW_STANDBY_PIN_N;
					s_d.cpu_halt = 1'b1; // RL2
					s_d.clock_run = 1'b0;
					s_d.module_reset = 1'b1;
					s_d.dma_reset = 1'b1;
					s_d.refresh_init = 1'b1; // RL3
				end
				if (s_q.res_seen && reset_pin_n) begin
					s_d.res_seen = 1'b0;
					s_d.reset_start = 1'b1; // RL18
					s_d.cpu_halt = 1'b0;
					s_d.module_reset = 1'b0;
					s_d.dma_reset = 1'b0;
				end
			end
			smc_pkg::SMC_SW_STANDBY_PIN_N: begin
				if (!reset_pin_n) begin // RL8
					s_d.mode = smc_pkg::SMC_RUN;
					s_d.clock_run = 1'b1;
					s_d.res_seen = 1'b1;
				end else if (wake) begin // RL6
					s_d.mode = smc_pkg::SMC_SETTLE;
					s_d.wait_cnt = wait_len;
				end
			end
			smc_pkg::SMC_SETTLE: begin
				if (!reset_pin_n) begin // RL8
					s_d.mode = smc_pkg::SMC_RUN;
					s_d.clock_run = 1'b1;
					s_d.res_seen = 1'b1;
				end else if (tick) begin // RL12
					s_d.wait_cnt = s_q.wait_cnt - 18'h00001;
					if (s_q.wait_cnt == 18'h00001) begin
						s_d.mode = smc_pkg::SMC_RUN;
						s_d.clock_run = 1'b1;
						s_d.cpu_halt = 1'b0;
						s_d.module_reset = 1'b0;
						s_d.dma_reset = 1'b0;
						s_d.intr_start = 1'b1;
					end
				end
			end
			smc_pkg::SMC_HW_STANDBY_PIN_N: begin
				if (standby_pin_n) begin // RL18
					s_d.mode = smc_pkg::SMC_RUN;
					s_d.clock_run = 1'b1;
					s_d.ports_hiz = 1'b0;
					s_d.res_seen = 1'b1;
				end
			end
		endcase
		// standby pin dominates every state
		if (!standby_pin_n) begin // RL15 RL10
			s_d.mode = smc_pkg::SMC_HW_STANDBY_PIN_N;
			s_d.cpu_halt = 1'b1;
			s_d.clock_run = 1'b0;
			s_d.module_reset = 1'b1;
			s_d.dma_reset = 1'b1;
			s_d.ports_hiz = 1'b1;
			s_d.intr_start = 1'b0;
			s_d.reset_start = 1'b0;
			s_d.res_seen = 1'b0;
			s_d.sysctl = smc_pkg::SYS_CTRL_RST;
			s_d.modhalt = smc_pkg::MOD_HALT_RST; // RL21
			s_d.presc = smc_pkg::PRESCALE_RST;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
			s_q.mode <= smc_pkg::SMC_RUN;
			s_q.sysctl <= smc_pkg::SYS_CTRL_RST;
			s_q.modhalt <= smc_pkg::MOD_HALT_RST;
			s_q.presc <= smc_pkg::PRESCALE_RST;
			s_q.clock_run <= 1'b1;
			s_q.nmi_prev <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign hrdata = s_q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign cpu_halt = s_q.cpu_halt;
	assign clock_run = s_q.clock_run;
	assign module_reset = s_q.module_reset;
	assign dma_reset = s_q.dma_reset;
	assign refresh_init = s_q.refresh_init;
	assign ports_hiz = s_q.ports_hiz;
	assign intr_start = s_q.intr_start;
	assign reset_start = s_q.reset_start;

	// checks
	a_sleep_enters: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
		(s_q.mode == smc_pkg::SMC_RUN && sleep_exec && s_q.sysctl[7] && standby_pin_n)
		|=> (s_q.mode == smc_pkg::SMC_SW_STANDBY_PIN_N && refresh_init && cpu_halt))
		else $error("sleep did not enter software standby");
	a_plain_sleep: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
		(s_q.mode == smc_pkg::SMC_RUN && sleep_exec && !s_q.sysctl[smc_pkg::SSEL_BIT]
		&& standby_pin_n) |=> (s_q.mode == smc_pkg::SMC_RUN && !refresh_init))
		else $error("sleep without standby select left run mode");
	a_masked_irq_stays: assert property (@(posedge hclk) disable iff (!hresetn) // RL7
		(s_q.mode == smc_pkg::SMC_SW_STANDBY_PIN_N && !nmi_edge && !irq_wake && reset_pin_n
		&& standby_pin_n) |=> s_q.mode == smc_pkg::SMC_SW_STANDBY_PIN_N)
		else $error("left standby without wake");
	a_wake_settles: assert property (@(posedge hclk) disable iff (!hresetn) // RL6
		(s_q.mode == smc_pkg::SMC_SW_STANDBY_PIN_N && wake && reset_pin_n && standby_pin_n)
		|=> (s_q.mode == smc_pkg::SMC_SETTLE && s_q.wait_cnt == $past(wait_len)))
		else $error("wake did not load settle count");
	a_settle_clock_off: assert property (@(posedge hclk) disable iff (!hresetn) // RL6
		s_q.mode == smc_pkg::SMC_SETTLE |-> (!clock_run && cpu_halt))
		else $error("clock supplied before settle wait ended");
	a_reset_immediate: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
		(s_q.mode == smc_pkg::SMC_SETTLE && !reset_pin_n && standby_pin_n)
		|=> clock_run)
		else $error("reset did not start clock at once");
	a_reset_rise: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
		(s_q.mode == smc_pkg::SMC_RUN && s_q.res_seen && reset_pin_n && standby_pin_n)
		|=> (reset_start && !cpu_halt))
		else $error("reset rise did not start reset handling");
	a_standby_pin_n_dominates: assert property (@(posedge hclk) disable iff (!hresetn) // RL15
		!standby_pin_n |=> (ports_hiz && module_reset && s_q.mode == smc_pkg::SMC_HW_STANDBY_PIN_N))
		else $error("standby pin did not force hardware standby");
	a_hw_regs_reset: assert property (@(posedge hclk) disable iff (!hresetn) // RL15 RL21
		!standby_pin_n |=> (s_q.sysctl == smc_pkg::SYS_CTRL_RST
		&& s_q.modhalt == smc_pkg::MOD_HALT_RST))
		else $error("registers not reset in hardware standby");
	a_hw_all_halted: assert property (@(posedge hclk) disable iff (!hresetn) // RL15
		s_q.mode == smc_pkg::SMC_HW_STANDBY_PIN_N |-> (!clock_run && cpu_halt && ports_hiz))
		else $error("hardware standby left something running");
	a_ssel_kept: assert property (@(posedge hclk) disable iff (!hresetn) // RL20
		intr_start |-> s_q.sysctl[7])
		else $error("standby select lost on interrupt exit");
	a_modhalt_kept: assert property (@(posedge hclk) disable iff (!hresetn) // RL21
		(s_q.mode == smc_pkg::SMC_SW_STANDBY_PIN_N && standby_pin_n) |=> $stable(s_q.modhalt))
		else $error("module halt changed in software standby");
	a_prescale_tick: assert property (@(posedge hclk) disable iff (!hresetn) // RL12
		(tick && s_q.presc == 2'h1) |=> !tick)
		else $error("prescaled tick too frequent");
	a_prescale_four: assert property (@(posedge hclk) disable iff (!hresetn) // RL12
		(tick && s_q.presc == 2'h2) |=> !tick ##1 !tick ##1 !tick)
		else $error("divide by four tick too frequent");
	a_edge_select: assert property (@(posedge hclk) disable iff (!hresetn) // RL14
		(s_q.mode == smc_pkg::SMC_SW_STANDBY_PIN_N && s_q.sysctl[smc_pkg::NMI_EDGE_SELECT_BIT] && !nmi_pin
		&& s_q.nmi_prev && !irq_wake && reset_pin_n && standby_pin_n)
		|=> s_q.mode == smc_pkg::SMC_SW_STANDBY_PIN_N)
		else $error("nmi wake on wrong edge");
	a_hw_exit_reset: assert property (@(posedge hclk) disable iff (!hresetn) // RL18
		(s_q.mode == smc_pkg::SMC_HW_STANDBY_PIN_N && standby_pin_n) |=> clock_run ##0 !ports_hiz)
		else $error("hardware standby exit did not start clock");
endmodule // smc_top
`default_nettype wire

// File: sim/smc_pin_model.sv
// Purpose: drives the external nmi, irq, reset and standby pins
// Assumes: pins change just after a rising hclk edge
// Notes: sim stands in for an external clock, so short settle holds are legal
`timescale 1ns/10ps
`default_nettype none
module smc_pin_model (
	input wire logic hclk,
	output logic nmi_pin,
	output logic [2:0] irq_pin_n,
	output logic reset_pin_n,
	output logic standby_pin_n
);
	// idle pin levels at time zero
	initial begin
		nmi_pin = 1'b0;
		irq_pin_n = 3'h7;
		reset_pin_n = 1'b1;
		standby_pin_n = 1'b1;
	end

	// one pin update, launched right after an edge
	task automatic drive(input logic nmi, input logic [2:0] irq, input logic rst, input logic stb);
		@(posedge hclk);
		nmi_pin <= nmi;
		irq_pin_n <= irq;
		reset_pin_n <= rst;
		standby_pin_n <= stb;
	endtask

	// reset goes low first, then the standby pin; mode pins are not driven, so never move
	task automatic enter_hw;
		drive(nmi_pin, 3'h7, 1'b0, 1'b1);
		drive(nmi_pin, 3'h7, 1'b0, 1'b0);
	endtask

	// reset is held low for hold+1 more hclk edges before it rises
	task automatic release_reset(input int hold);
		repeat (hold) @(posedge hclk);
		drive(nmi_pin, 3'h7, 1'b1, 1'b1);
	endtask
endmodule // smc_pin_model
`default_nettype wire

// File: sim/testbench.sv
// Purpose: self-checking bench for the standby mode controller
// Assumes: hready follows hreadyout; one bus master
// Notes: settle tests use code 101 so the run stays short
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, sleep_exec = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, junk;
	logic [1:0] htrans = 2'h0;
	logic [2:0] irq_pin_n, irq_enable = 3'h0, irq_cpu_mask = 3'h0;
	logic hreadyout, hresp, nmi_pin, reset_pin_n, standby_pin_n, cpu_halt, clock_run;
	logic module_reset, dma_reset, refresh_init, ports_hiz, intr_start, reset_start;
	int failures = 0, n_checks = 0;

	// 100 MHz clock
	always #5 hclk = ~hclk;

	smc_pin_model pm (.hclk(hclk), .nmi_pin(nmi_pin), .irq_pin_n(irq_pin_n),
		.reset_pin_n(reset_pin_n), .standby_pin_n(standby_pin_n));
	smc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .sleep_exec(sleep_exec), .nmi_pin(nmi_pin),
		.irq_pin_n(irq_pin_n), .irq_enable(irq_enable), .irq_cpu_mask(irq_cpu_mask),
		.reset_pin_n(reset_pin_n), .standby_pin_n(standby_pin_n), .cpu_halt(cpu_halt),
		.clock_run(clock_run), .module_reset(module_reset), .dma_reset(dma_reset),
		.refresh_init(refresh_init), .ports_hiz(ports_hiz), .intr_start(intr_start),
		.reset_start(reset_start));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one AHB single transfer: address phase, then data phase
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		bus(1'b0, a, 32'h0, v);
		chk(v, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask

	// sleep pulse; refresh init must follow only on standby entry
	task automatic sleep(input logic exp_init);
		@(posedge hclk);
		sleep_exec <= 1'b1;
		@(posedge hclk);
		sleep_exec <= 1'b0;
		#1;
		chk({31'h0, refresh_init}, {31'h0, exp_init});
	endtask

	// bounded wait for a start pulse, then its latency is judged
	task automatic wait_out(input bit intr, input int lo, input int hi);
		int n;
		n = 0;
		while ((intr ? intr_start : reset_start) !== 1'b1 && n <= hi) begin
			@(posedge hclk);
			#1;
			n++;
		end
		chk({31'h0, n >= lo && n <= hi}, 32'h1);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// watchdog: the whole sequence needs well under 20000 cycles
	initial begin
		repeat (40000) @(posedge hclk);
		failures++;
		$display("ERROR %0t: timeout", $time);
		tally_and_finish();
	end

	// main sequence
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		rd(smc_pkg::SYS_CTRL_OFF, 32'h0B);
		rd(smc_pkg::MOD_HALT_OFF, 32'h40);
		rd(smc_pkg::STATUS_OFF, 32'h0);
		rd(8'h80, 32'h0);
		bus(1'b1, smc_pkg::MOD_HALT_OFF, 32'h05, junk);
		rd(smc_pkg::MOD_HALT_OFF, 32'h45);
		sleep(1'b0);
		rd(smc_pkg::STATUS_OFF, 32'h0);
		// ram enable stays clear ahead of any hardware standby
		// watchdog and bus release stay off; external clock lets any settle code stand
		bus(1'b1, smc_pkg::SYS_CTRL_OFF, 32'hD0, junk);
		sleep(1'b1);
		chk({28'h0, cpu_halt, clock_run, dma_reset, module_reset}, 32'hB);
		pm.drive(1'b0, 3'h6, 1'b1, 1'b1);
		repeat (20) @(posedge hclk);
		rd(smc_pkg::STATUS_OFF, 32'h1);
		irq_enable <= 3'h1;
		irq_cpu_mask <= 3'h1;
		repeat (20) @(posedge hclk);
		rd(smc_pkg::STATUS_OFF, 32'h1);
		irq_cpu_mask <= 3'h0;
		wait_out(1'b1, 1024, 1032);
		pm.drive(1'b0, 3'h7, 1'b1, 1'b1);
		#1;
		chk({30'h0, cpu_halt, clock_run}, 32'h1);
		rd(smc_pkg::SYS_CTRL_OFF, 32'hD0);
		rd(smc_pkg::MOD_HALT_OFF, 32'h45);
		// rising nmi edge with prescale step 1 doubles the wait
		bus(1'b1, smc_pkg::PRESCALE_OFF, 32'h1, junk);
		bus(1'b1, smc_pkg::SYS_CTRL_OFF, 32'hD8, junk);
		pm.drive(1'b1, 3'h7, 1'b1, 1'b1);
		sleep(1'b1);
		pm.drive(1'b0, 3'h7, 1'b1, 1'b1);
		repeat (10) @(posedge hclk);
		rd(smc_pkg::STATUS_OFF, 32'h1);
		pm.drive(1'b1, 3'h7, 1'b1, 1'b1);
		wait_out(1'b1, 2048, 2056);
		// reset pin exit: clocks at once, reset handling on the rise
		sleep(1'b1);
		pm.drive(1'b1, 3'h7, 1'b0, 1'b1);
		repeat (2) @(posedge hclk);
		#1;
		chk({30'h0, clock_run, reset_start}, 32'h2);
		pm.release_reset(20);
		wait_out(1'b0, 0, 4);
		// reset low takes software standby back to run, then hardware standby and back out
		bus(1'b1, smc_pkg::SYS_CTRL_OFF, 32'hD0, junk);
		sleep(1'b1);
		pm.enter_hw();
		repeat (3) @(posedge hclk);
		chk({31'h0, ports_hiz}, 32'h1);
		rd(smc_pkg::STATUS_OFF, 32'h3);
		pm.drive(1'b1, 3'h7, 1'b0, 1'b1);
		repeat (3) @(posedge hclk);
		#1;
		chk({30'h0, clock_run, ports_hiz}, 32'h2);
		pm.release_reset(20);
		wait_out(1'b0, 0, 4);
		rd(smc_pkg::MOD_HALT_OFF, 32'h40);
		rd(smc_pkg::SYS_CTRL_OFF, 32'h0B);
		tally_and_finish();
	end
endmodule // testbench
`default_nettype wire
